// *** common/fsc_pkg.sv ***
// constants, states and state records for the fan speed port control block
package fsc_pkg;

    // spin-up interval at full speed, and the clock rate it is counted in
    localparam int unsigned SPINUP_MS  = 1000;
    localparam int unsigned CLK_KHZ    = 250000;
    localparam int unsigned SPINUP_CYC = SPINUP_MS * CLK_KHZ;

    // upper port pins: index 3 is fan_off_n, 2..0 are speed bits 2..0
    localparam int unsigned PIN_W      = 4;
    localparam int unsigned SPD_W      = 3;
    localparam int unsigned OFF_IDX    = 3;

    // pin enable patterns and reset values
    localparam logic [3:0]  OE_RESET   = 4'h0;
    localparam logic [3:0]  OE_SHUT    = 4'h8;
    localparam logic [2:0]  SPD_FULL   = 3'h7;
    localparam logic [2:0]  SPD_ZERO   = 3'h0;
    localparam logic [3:0]  PIN_RESET  = 4'hF;
    localparam logic [3:0]  CHG_RESET  = 4'h0;

    // fan sequencer states, one-hot
    typedef enum logic [3:0] {
        FSC_IDLE = 4'b0001,
        FSC_SHUT = 4'b0010,
        FSC_SPIN = 4'b0100,
        FSC_RUN  = 4'b1000
    } fsc_state_e;

    // whole state of the sequencer
    typedef struct packed {
        fsc_state_e  st;
        logic [3:0]  oe;
        logic [3:0]  prev;
        logic [3:0]  chg;
    } fsc_ctrl_s;

    // whole state of the spin-up timer
    typedef struct packed {
        logic        busy;
        logic [31:0] cnt;
    } fsc_tmr_s;

endpackage

// *** common/fsc_tmr_if.sv ***
// handshake between the fan sequencer and its spin-up timer
`timescale 1ns/1ns
interface fsc_tmr_if;
    logic start;
    logic abort;
    logic done;

    modport ctrl (output start, output abort, input done);
    modport tmr  (input start, input abort, output done);
endinterface

// *** hdl/fsc_spin_timer.sv ***
// spin-up interval timer for the fan sequencer
`timescale 1ns/1ns
module fsc_spin_timer #(
    parameter int unsigned CYCLES = fsc_pkg::SPINUP_CYC
) (
    // clock and reset
    input  wire logic  mclk,
    input  wire logic  rst,
    // sequencer side
    fsc_tmr_if.tmr     tif
);

    fsc_pkg::fsc_tmr_s cur;
    fsc_pkg::fsc_tmr_s next_cur;

    // done stands in the last cycle of the interval only
    assign tif.done = cur.busy && (cur.cnt == 32'h0);

    // load, count down, stop; abort wins so a dropped spin-up leaves no
    // stale done behind
    always_comb
    begin
        next_cur = cur;
        if (tif.abort)
        begin
            next_cur.busy = 1'b0;
        end
        else if (tif.start)
        begin
            next_cur.busy = 1'b1;
            next_cur.cnt  = 32'(CYCLES - 1);
        end
        else if (cur.busy && cur.cnt != 32'h0)
        begin
            next_cur.cnt = cur.cnt - 32'h1;
        end
        else if (tif.done)
        begin
            next_cur.busy = 1'b0;
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cur <= '0;
        end
        else
        begin
            cur <= next_cur;
        end
    end

endmodule

// *** hdl/fsc_fan_ctrl.sv ***
// fan speed sequencer driving the upper port pins as open-drain outputs
`timescale 1ns/1ns

module fsc_fan_ctrl #(
    parameter int unsigned SPINUP_CYCLES = fsc_pkg::SPINUP_CYC
) (
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        rst,
    // configuration from the device registers
    input  wire logic        fan_mode_en,
    input  wire logic [7:0]  fan_speed,
    // upper port pins, open drain
    input  wire logic [3:0]  pin_in,
    output logic      [3:0]  pin_out,
    output logic      [3:0]  pin_oe,
    // change events towards the status register
    output logic      [3:0]  chg_evt
);

    fsc_pkg::fsc_ctrl_s cur;
    fsc_pkg::fsc_ctrl_s next_cur;
    fsc_tmr_if          tif ();
    logic [2:0]         spd;
    logic               spd_zero;

    // only the low three bits select a speed; upper bits are don't-care
    assign spd      = fan_speed[2:0];
    assign spd_zero = (spd == fsc_pkg::SPD_ZERO);

    // spin-up interval timer
    fsc_spin_timer #(
        .CYCLES (SPINUP_CYCLES)
    ) u_timer (
        .mclk   (mclk),
        .rst    (rst),
        .tif    (tif)
    );

    // outputs straight from the state record; the pin level is always
    // low so a released pin can never be driven high
    assign pin_out = 4'h0;
    assign pin_oe  = cur.oe;
    assign chg_evt = cur.chg;

    // sequencer, pin pattern and change detection
    always_comb
    begin
        next_cur  = cur;
        tif.start = 1'b0;
        tif.abort = 1'b0;
        next_cur.prev = pin_in;
        // events are masked at the source while fan mode owns the pins
        next_cur.chg  = (pin_in ^ cur.prev) & {4{~fan_mode_en}};
        unique case (cur.st)
            fsc_pkg::FSC_IDLE:
            begin
                if (fan_mode_en)
                begin
                    next_cur.st = spd_zero ? fsc_pkg::FSC_SHUT
                                           : fsc_pkg::FSC_SPIN;
                end
            end
            fsc_pkg::FSC_SHUT:
            begin
                if (!fan_mode_en)
                begin
                    next_cur.st = fsc_pkg::FSC_IDLE;
                end
                else if (!spd_zero)
                begin
                    next_cur.st = fsc_pkg::FSC_SPIN;
                end
            end
            fsc_pkg::FSC_SPIN:
            begin
                if (!fan_mode_en)
                begin
                    next_cur.st = fsc_pkg::FSC_IDLE;
                end
                else if (spd_zero)
                begin
                    next_cur.st = fsc_pkg::FSC_SHUT;
                end
                else if (tif.done)
                begin
                    next_cur.st = fsc_pkg::FSC_RUN;
                end
            end
            fsc_pkg::FSC_RUN:
            begin
                if (!fan_mode_en)
                begin
                    next_cur.st = fsc_pkg::FSC_IDLE;
                end
                else if (spd_zero)
                begin
                    next_cur.st = fsc_pkg::FSC_SHUT;
                end
            end
            default:
            begin
                next_cur.st = fsc_pkg::FSC_IDLE;
            end
        endcase
        // timer follows the spin state: started on entry, dropped on exit
        tif.start = (next_cur.st == fsc_pkg::FSC_SPIN)
                    && (cur.st != fsc_pkg::FSC_SPIN);
        tif.abort = (cur.st == fsc_pkg::FSC_SPIN)
                    && (next_cur.st != fsc_pkg::FSC_SPIN);
        // pin pattern is registered with the state so they never disagree
        unique case (next_cur.st)
            fsc_pkg::FSC_SHUT: next_cur.oe = fsc_pkg::OE_SHUT;
            fsc_pkg::FSC_SPIN: next_cur.oe = {1'b0, fsc_pkg::SPD_FULL};
            fsc_pkg::FSC_RUN:  next_cur.oe = {1'b0, spd};
            default:           next_cur.oe = fsc_pkg::OE_RESET;
        endcase
    end

    // state register; pins float from reset onward
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            cur.st   <= fsc_pkg::FSC_IDLE;
            cur.oe   <= fsc_pkg::OE_RESET;
            cur.prev <= fsc_pkg::PIN_RESET;
            cur.chg  <= fsc_pkg::CHG_RESET;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // helper: length of the current spin-up in cycles
    logic [31:0] spin_len;
    always_ff @(posedge mclk)
    begin
        if (rst || cur.st != fsc_pkg::FSC_SPIN)
        begin
            spin_len <= 32'h0;
        end
        else
        begin
            spin_len <= spin_len + 32'h1;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (rst);

    a_reset_float: assert property (
        disable iff (1'b0) rst |=> (pin_oe == 4'h0 && chg_evt == 4'h0))
        else $error("pins not released after reset");

    a_enable_zero_shut: assert property (
        $rose(fan_mode_en) && spd_zero |=> pin_oe == 4'h8)
        else $error("zero speed enable did not assert fan_off_n");

    a_spin_full_speed: assert property (
        cur.st == fsc_pkg::FSC_SPIN |-> pin_oe == 4'h7)
        else $error("spin-up not at full speed");

    a_spin_exact_len: assert property (
        $past(cur.st) == fsc_pkg::FSC_SPIN && cur.st == fsc_pkg::FSC_RUN
        |-> $past(spin_len) == 32'(SPINUP_CYCLES - 1))
        else $error("spin-up interval has the wrong length");

    a_spin_no_overrun: assert property (
        cur.st == fsc_pkg::FSC_SPIN |-> spin_len < 32'(SPINUP_CYCLES))
        else $error("spin-up lasted too long");

    a_run_speed_map: assert property (
        cur.st == fsc_pkg::FSC_RUN |-> pin_oe == {1'b0, $past(spd)})
        else $error("run pins do not match speed setting");

    a_drain_only: assert property (
        pin_out == 4'h0 && (cur.st != fsc_pkg::FSC_IDLE || pin_oe == 4'h0))
        else $error("pin driven high or driven while idle");

    a_enable_starts: assert property (
        cur.st == fsc_pkg::FSC_IDLE && fan_mode_en && !spd_zero
        |=> cur.st == fsc_pkg::FSC_SPIN && pin_oe == 4'h7)
        else $error("enable with speed did not start spin-up");

    a_events_masked: assert property (
        $past(fan_mode_en) |-> chg_evt == 4'h0)
        else $error("change event raised in fan mode");

    a_off_pin_top: assert property (
        cur.st == fsc_pkg::FSC_SHUT |-> pin_oe[3] && pin_oe[2:0] == 3'h0)
        else $error("fan_off_n not on the top pin");

    // zero speed shuts the fan from any state, not only from idle
    a_zero_shuts: assert property (
        fan_mode_en && spd_zero |=> pin_oe == 4'h8)
        else $error("zero speed in fan mode did not shut the fan");

    // leaving fan mode must hand every upper pin back at once
    a_disable_floats: assert property (
        !fan_mode_en |=> pin_oe == 4'h0)
        else $error("pins still pulled after fan mode left");

    c_spin_to_run: cover property (
        cur.st == fsc_pkg::FSC_SPIN ##1 cur.st == fsc_pkg::FSC_RUN);
    c_shut_to_spin: cover property (
        cur.st == fsc_pkg::FSC_SHUT ##1 cur.st == fsc_pkg::FSC_SPIN);
    c_spin_dropped: cover property (
        cur.st == fsc_pkg::FSC_SPIN ##1 cur.st == fsc_pkg::FSC_IDLE);
    c_change_seen: cover property (chg_evt != 4'h0);
    c_run_to_shut: cover property (
        cur.st == fsc_pkg::FSC_RUN ##1 cur.st == fsc_pkg::FSC_SHUT);

endmodule

// *** verif/fsc_fan_net.sv ***
// regulator feedback network model seen by the upper port pins
`timescale 1ns/1ns
module fsc_fan_net (
    // pin drive from the block
    input  wire logic [3:0] pin_out,
    input  wire logic [3:0] pin_oe,
    // jumpers that ground a pin from outside
    input  wire logic [3:0] ext_low,
    // resolved levels and regulator view
    output logic      [3:0] pin_lvl,
    output logic            fan_stop,
    output logic      [2:0] fb_grounded
);
    // pull-ups float a released pin high; a driven-high pin shows up high
    always_comb
    begin
        for (int i = 0; i < 4; i++)
            pin_lvl[i] = ext_low[i] ? 1'b0
                                    : (pin_oe[i] ? pin_out[i] : 1'b1);
    end

    // low top pin stops the regulator, low speed pins add feedback weight
    assign fan_stop    = ~pin_lvl[3];
    assign fb_grounded = ~pin_lvl[2:0];
endmodule

// *** verif/fan_speed_port_control_bench.sv ***
// directed testbench for the fan speed sequencer
`timescale 1ns/1ns
module fan_speed_port_control_bench;
    localparam int unsigned SPIN = 20;
    logic       mclk, rst, fan_mode_en, fan_stop;
    logic [7:0] fan_speed;
    logic [3:0] pin_in, pin_out, pin_oe, chg_evt, ext_low;
    logic [2:0] fb_grounded;
    int         err_count, tests_run, n;

    fsc_fan_ctrl #(.SPINUP_CYCLES(SPIN)) dut_u (.mclk(mclk), .rst(rst),
        .fan_mode_en(fan_mode_en), .fan_speed(fan_speed), .pin_in(pin_in),
        .pin_out(pin_out), .pin_oe(pin_oe), .chg_evt(chg_evt));
    fsc_fan_net net_u (.pin_out(pin_out), .pin_oe(pin_oe),
        .ext_low(ext_low), .pin_lvl(pin_in), .fan_stop(fan_stop),
        .fb_grounded(fb_grounded));

    // 250 MHz clock
    always #2 mclk = ~mclk;

    task automatic check(input string what, input logic [7:0] seen,
                         input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic tick(input int k);
        repeat (k) @(negedge mclk);
    endtask

    // host writes the whole setting in one go; do_reset also writes it directly
    task automatic set_cfg(input logic en, input logic [7:0] spd);
        fan_mode_en = en;
        fan_speed   = spd;
        tick(1);
    endtask

    task automatic do_reset();
        rst = 1'b1;
        fan_mode_en = 1'b0;
        fan_speed = 8'h00;
        ext_low = 4'h0;
        tick(1);
        check("oe in reset", pin_oe, 8'h00);
        tick(11);
        rst = 1'b0;
        tick(2);
        check("oe idle", pin_oe, 8'h00);
        check("out idle", pin_out, 8'h00);
        check("evt idle", chg_evt, 8'h00);
        check("stop idle", fan_stop, 8'h00);
    endtask

    // enabling with zero speed shuts the fan, pin moves raise no event
    task automatic t_shut();
        set_cfg(1'b1, 8'h00);
        check("oe shut", pin_oe, 8'h08);
        check("stop shut", fan_stop, 8'h01);
        repeat (3)
        begin
            tick(1);
            check("evt shut", chg_evt, 8'h00);
        end
    endtask

    // nonzero speed spins flat out for the interval, then settles
    task automatic t_spin();
        set_cfg(1'b1, 8'h03);
        check("fb spin", fb_grounded, 8'h07);
        check("stop spin", fan_stop, 8'h00);
        n = 0;
        while (pin_oe === 4'h7 && n < 100)
        begin
            n++;
            tick(1);
        end
        check("spin len", n[7:0], SPIN[7:0]);
        check("oe run", pin_oe, 8'h03);
        check("fb run", fb_grounded, 8'h03);
    endtask

    // each speed grounds its weights; upper setting bits are ignored
    task automatic t_speeds();
        for (int s = 1; s < 8; s++)
        begin
            set_cfg(1'b1, {5'h1F, s[2:0]});
            check("oe speed", pin_oe, {5'h00, s[2:0]});
            check("out speed", pin_out, 8'h00);
        end
        set_cfg(1'b0, 8'h07);
        check("oe off", pin_oe, 8'h00);
    endtask

    // events seen with fan mode off, masked with it on
    task automatic t_chg();
        // the pins released by leaving fan mode rise once as plain inputs;
        // let that change pass so it does not mix with the jumper below
        tick(1);
        check("oe disabled", pin_oe, 8'h00);
        ext_low = 4'h2;
        tick(1);
        check("evt fall", chg_evt, 8'h02);
        tick(1);
        check("evt pulse", chg_evt, 8'h00);
        ext_low = 4'h0;
        tick(1);
        check("evt rise", chg_evt, 8'h02);
        set_cfg(1'b1, 8'h00);
        tick(2);
        ext_low = 4'h1;
        tick(1);
        check("evt masked", chg_evt, 8'h00);
        ext_low = 4'h0;
        tick(1);
        check("evt masked", chg_evt, 8'h00);
    endtask

    // speed dropped or mode left mid spin-up; a new spin-up is full length
    task automatic t_abort();
        set_cfg(1'b1, 8'h05);
        check("oe respin", pin_oe, 8'h07);
        tick(3);
        set_cfg(1'b1, 8'h00);
        check("oe spin zero", pin_oe, 8'h08);
        set_cfg(1'b1, 8'h05);
        tick(3);
        set_cfg(1'b0, 8'h05);
        check("oe spin drop", pin_oe, 8'h00);
        tick(2);
        check("oe held off", pin_oe, 8'h00);
        set_cfg(1'b1, 8'h05);
        n = 0;
        while (pin_oe === 4'h7 && n < 100)
        begin
            n++;
            tick(1);
        end
        check("respin len", n[7:0], SPIN[7:0]);
        check("oe run 5", pin_oe, 8'h05);
        set_cfg(1'b1, 8'h00);
        check("oe run zero", pin_oe, 8'h08);
    endtask

    task automatic print_verdict();
        $display("checks %0d errors %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    // main sequence; a second reset lands in mid-run
    initial
    begin
        mclk = 1'b0;
        err_count = 0;
        tests_run = 0;
        do_reset();
        t_shut();
        t_spin();
        do_reset();
        t_shut();
        t_spin();
        t_speeds();
        t_chg();
        t_abort();
        print_verdict();
    end

    // the run needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge mclk);
        err_count++;
        print_verdict();
    end
endmodule
